// File: include/serial_rx_defs.svh
`ifndef SERIAL_RX_DEFS_SVH
`define SERIAL_RX_DEFS_SVH

// ****************************************************
// Clock and timing
// ****************************************************
`define CORE_CLK_HZ 40000000
`define MS_PER_S 1000
`define IDLE_UNIT_MS 1

// ****************************************************
// Register byte offsets
// ****************************************************
`define REG_CTRL 5'h00
`define REG_SERIAL 5'h04
`define REG_IDLE 5'h08
`define REG_MATCH 5'h0C
`define REG_TRAIL 5'h10
`define REG_STATUS 5'h14

// ****************************************************
// Fields and reset values
// ****************************************************
`define CTRL_DIS 0
`define CTRL_PACK 1
`define CTRL_ALT 2
`define CTRL_FRAME 3
`define CTRL_RST 4'h0
`define SER_BAUD 3:0
`define SER_BITS 5:4
`define SER_PAR 7:6
`define SER_STOP2 8
`define SER_RST 9'h035
`define IDLE_RST 8'h0C
`define MATCH_RST 16'h0000
`define TRAIL_RST 8'h00
`define MATCH_OFF 8'h00
`define MATCH_B1 7:0
`define MATCH_B2 15:8
`define ST_PAR 0
`define ST_FRM 1
`define ST_OVR 2
`define DATA_LAST_BASE 3'h4

// ****************************************************
// Bit rates
// ****************************************************
`define BAUD_300 300
`define BAUD_600 600
`define BAUD_1200 1200
`define BAUD_2400 2400
`define BAUD_4800 4800
`define BAUD_9600 9600
`define BAUD_19200 19200
`define BAUD_38400 38400
`define BAUD_57600 57600
`define BAUD_115200 115200
`define BAUD_230400 230400
`define BAUD_460800 460800
`define BAUD_921600 921600

`endif

// File: include/serial_rx_pkg.sv
package serial_rx_pkg;
`include "serial_rx_defs.svh"

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h3,
    RX_PAR = 3'h2,
    RX_STOP = 3'h6
  } rx_state_e;

  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ODD = 2'h1,
    PAR_EVEN = 2'h2,
    PAR_RSVD = 2'h3
  } parity_e;

  typedef logic [17:0] baud_div_t;

  // Bit period in core clocks for a rate selection
  function automatic baud_div_t baud_div(input logic [3:0] sel);
    case (sel)
      4'h0: baud_div = baud_div_t'(`CORE_CLK_HZ / `BAUD_300);
      4'h1: baud_div = baud_div_t'(`CORE_CLK_HZ / `BAUD_600);
      4'h2: baud_div = baud_div_t'(`CORE_CLK_HZ / `BAUD_1200);
      4'h3: baud_div = baud_div_t'(`CORE_CLK_HZ / `BAUD_2400);
      4'h4: baud_div = baud_div_t'(`CORE_CLK_HZ / `BAUD_4800);
      4'h6: baud_div = baud_div_t'(`CORE_CLK_HZ / `BAUD_19200);
      4'h7: baud_div = baud_div_t'(`CORE_CLK_HZ / `BAUD_38400);
      4'h8: baud_div = baud_div_t'(`CORE_CLK_HZ / `BAUD_57600);
      4'h9: baud_div = baud_div_t'(`CORE_CLK_HZ / `BAUD_115200);
      4'hA: baud_div = baud_div_t'(`CORE_CLK_HZ / `BAUD_230400);
      4'hB: baud_div = baud_div_t'(`CORE_CLK_HZ / `BAUD_460800);
      4'hC: baud_div = baud_div_t'(`CORE_CLK_HZ / `BAUD_921600);
      default: baud_div = baud_div_t'(`CORE_CLK_HZ / `BAUD_9600);
    endcase
  endfunction : baud_div

  // Byte-enable merge of a write into a register word
  function automatic logic [31:0] be_merge(input logic [31:0] cur,
                                           input logic [31:0] wr,
                                           input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      be_merge[i*8 +: 8] = be[i] ? wr[i*8 +: 8] : cur[i*8 +: 8];
    end
  endfunction : be_merge

endpackage : serial_rx_pkg

// File: rtl/serial_rx_fifo.sv
`timescale 1ns/1ps
module serial_rx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  // Fill level
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign o_in_ready = (cnt_q != CNT_FULL);
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem[rd_q];
  assign o_count = cnt_q;
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
    end
    case ({push, pop})
      2'h2: cnt_d = cnt_q + 1'b1;
      2'h1: cnt_d = cnt_q - 1'b1;
      default: cnt_d = cnt_q;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem[wr_q] <= i_in_data;
    end
  end
endmodule : serial_rx_fifo

// File: rtl/serial_uart_rx.sv
`timescale 1ns/1ps
module serial_uart_rx
  import serial_rx_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Configuration
  input wire logic i_enable,
  input wire baud_div_t i_div,
  input wire logic [1:0] i_bits,
  input wire logic [1:0] i_parity,
  input wire logic i_two_stop,
  // Serial line
  input wire logic i_rxd,
  // Received character
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_parity_err,
  output logic o_frame_err
);
  rx_state_e st_q, st_d;
  baud_div_t cnt_q, cnt_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, data_d;
  logic par_q, par_d, stop2_q, stop2_d, ferr_q, ferr_d, perr_q, perr_d;
  logic valid_d, operr_d, oferr_d, tick, par_on;

  assign tick = (cnt_q == '0);
  assign par_on = (i_parity == PAR_ODD) || (i_parity == PAR_EVEN);

  always_comb begin
    st_d = st_q;
    cnt_d = (cnt_q != '0) ? cnt_q - 18'h00001 : cnt_q;
    bit_d = bit_q;
    sh_d = sh_q;
    par_d = par_q;
    stop2_d = stop2_q;
    ferr_d = ferr_q;
    perr_d = perr_q;
    valid_d = 1'b0;
    data_d = o_data;
    operr_d = o_parity_err;
    oferr_d = o_frame_err;
    case (st_q)
      RX_IDLE: begin
        if (i_enable && !i_rxd) begin
          st_d = RX_START;
          cnt_d = i_div >> 1;
        end
      end
      RX_START: begin
        if (tick) begin
          if (i_rxd) begin
            st_d = RX_IDLE;
          end else begin
            st_d = RX_DATA;
            cnt_d = i_div - 18'h00001;
            bit_d = 3'h0;
            par_d = 1'b0;
            stop2_d = 1'b0;
            ferr_d = 1'b0;
            perr_d = 1'b0;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          sh_d = {i_rxd, sh_q[7:1]};
          par_d = par_q ^ i_rxd;
          bit_d = bit_q + 3'h1;
          cnt_d = i_div - 18'h00001;
          if (bit_q == `DATA_LAST_BASE + {1'b0, i_bits}) begin
            st_d = par_on ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (tick) begin
          perr_d = ((par_q ^ i_rxd) != (i_parity == PAR_ODD));
          st_d = RX_STOP;
          cnt_d = i_div - 18'h00001;
        end
      end
      RX_STOP: begin
        if (tick) begin
          ferr_d = ferr_q | ~i_rxd;
          if (i_two_stop && !stop2_q) begin
            stop2_d = 1'b1;
            cnt_d = i_div - 18'h00001;
          end else begin
            st_d = RX_IDLE;
            valid_d = 1'b1;
            data_d = sh_q >> (2'h3 - i_bits);
            operr_d = perr_q;
            oferr_d = ferr_q | ~i_rxd;
          end
        end
      end
      default: st_d = RX_IDLE;
    endcase
    if (!i_enable) begin
      st_d = RX_IDLE;
      valid_d = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      st_q <= RX_IDLE;
      cnt_q <= '0;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      par_q <= 1'b0;
      stop2_q <= 1'b0;
      ferr_q <= 1'b0;
      perr_q <= 1'b0;
      o_valid <= 1'b0;
      o_data <= 8'h00;
      o_parity_err <= 1'b0;
      o_frame_err <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      par_q <= par_d;
      stop2_q <= stop2_d;
      ferr_q <= ferr_d;
      perr_q <= perr_d;
      o_valid <= valid_d;
      o_data <= data_d;
      o_parity_err <= operr_d;
      o_frame_err <= oferr_d;
    end
  end
endmodule : serial_uart_rx

// File: rtl/serial_rx_packing_unit.sv
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "serial_rx_defs.svh"

module serial_rx_packing_unit
  import serial_rx_pkg::*;
#(
  parameter bit CHANNEL_ONE = 1'b1,
  parameter int IDLE_TICK_CYCLES =
    `CORE_CLK_HZ / `MS_PER_S * `IDLE_UNIT_MS,
  parameter int STD_MAX_LEN = 64,
  parameter int ALT_MAX_LEN = 1024,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Avalon-MM register slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Serial line
  input wire logic i_serial_rxd,
  output logic o_serial_txd,
  // Packet stream to network
  output logic o_pkt_valid,
  output logic [7:0] o_pkt_data,
  output logic o_pkt_last,
  input wire logic i_pkt_ready
);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;
  localparam logic [15:0] TICK_LAST = 16'(IDLE_TICK_CYCLES - 1);
  localparam logic [10:0] STD_LAST = 11'(STD_MAX_LEN - 1);
  localparam logic [10:0] ALT_LAST = 11'(ALT_MAX_LEN - 1);

  // ****************************************************
  // Declarations
  // ****************************************************
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d, cur_word, wr_word;
  logic [3:0] ctrl_q, ctrl_d;
  logic [8:0] serial_q, serial_d;
  logic [7:0] idle_q, idle_d, trail_cfg_q, trail_cfg_d;
  logic [15:0] match_q, match_d;
  logic [2:0] status_q, status_d, st_set, st_clr;
  logic bus_req, port_dis, pack_en, match_en, hit, end_now, len_full;
  logic rx_valid, rx_perr, rx_ferr, byte_in, ovr_set, idle_hit;
  logic [7:0] rx_data;
  logic hold_valid_q, hold_valid_d, hold_close_q, hold_close_d;
  logic [7:0] hold_data_q, hold_data_d, prev_q, prev_d;
  logic prev_valid_q, prev_valid_d, trail_act_q, trail_act_d;
  logic [7:0] trail_cnt_q, trail_cnt_d;
  logic [10:0] len_q, len_d;
  logic [15:0] tick_q, tick_d;
  logic [7:0] ms_q, ms_d;
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [8:0] f_out_data;
  logic [CW-1:0] f_count;
  logic ov_d, olast_d, txd_d, load;
  logic [7:0] od_d;

  assign bus_req = i_avs_read | i_avs_write;
  assign port_dis = CHANNEL_ONE & ctrl_q[`CTRL_DIS];
  assign pack_en = ctrl_q[`CTRL_PACK];

  // ****************************************************
  // Register file
  // ****************************************************
  always_comb begin
    case (i_avs_address)
      `REG_CTRL: cur_word = {28'h0000000, ctrl_q};
      `REG_SERIAL: cur_word = {23'h000000, serial_q};
      `REG_IDLE: cur_word = {24'h000000, idle_q};
      `REG_MATCH: cur_word = {16'h0000, match_q};
      `REG_TRAIL: cur_word = {24'h000000, trail_cfg_q};
      `REG_STATUS: cur_word = {24'h000000, f_count[3:0],
                               hold_valid_q, status_q};
      default: cur_word = 32'h00000000;
    endcase
  end

  assign wr_word = be_merge(cur_word, i_avs_writedata, i_avs_byteenable);
  assign st_set = {ovr_set, rx_valid & rx_ferr, rx_valid & rx_perr};

  always_comb begin
    wait_d = ~(bus_req & wait_q);
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    serial_d = serial_q;
    idle_d = idle_q;
    match_d = match_q;
    trail_cfg_d = trail_cfg_q;
    st_clr = 3'h0;
    if (i_avs_read && wait_q) begin
      rdata_d = cur_word;
    end
    if (i_avs_write && !wait_q) begin
      case (i_avs_address)
        `REG_CTRL: begin
          ctrl_d = wr_word[3:0];
          if (!CHANNEL_ONE) begin
            ctrl_d[`CTRL_DIS] = 1'b0;
          end
        end
        `REG_SERIAL: serial_d = wr_word[8:0];
        `REG_IDLE: idle_d = wr_word[7:0];
        `REG_MATCH: match_d = wr_word[15:0];
        `REG_TRAIL: trail_cfg_d = wr_word[7:0];
        `REG_STATUS: st_clr = i_avs_writedata[2:0] & {3{i_avs_byteenable[0]}};
        default: st_clr = 3'h0;
      endcase
    end
    status_d = (status_q & ~st_clr) | st_set;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
      ctrl_q <= `CTRL_RST;
      serial_q <= `SER_RST;
      idle_q <= `IDLE_RST;
      match_q <= `MATCH_RST;
      trail_cfg_q <= `TRAIL_RST;
      status_q <= 3'h0;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      serial_q <= serial_d;
      idle_q <= idle_d;
      match_q <= match_d;
      trail_cfg_q <= trail_cfg_d;
      status_q <= status_d;
    end
  end

  assign o_avs_waitrequest = wait_q;
  assign o_avs_readdata = rdata_q;

  // ****************************************************
  // Serial receiver
  // ****************************************************
  serial_uart_rx u_rx (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_enable(~port_dis),
    .i_div(baud_div(serial_q[`SER_BAUD])),
    .i_bits(serial_q[`SER_BITS]),
    .i_parity(serial_q[`SER_PAR]),
    .i_two_stop(serial_q[`SER_STOP2]),
    .i_rxd(i_serial_rxd),
    .o_valid(rx_valid),
    .o_data(rx_data),
    .o_parity_err(rx_perr),
    .o_frame_err(rx_ferr)
  );

  // ****************************************************
  // Idle gap timer
  // ****************************************************
  always_comb begin
    tick_d = tick_q + 16'h0001;
    ms_d = ms_q;
    if (rx_valid || !hold_valid_q || hold_close_q) begin
      tick_d = 16'h0000;
      ms_d = 8'h00;
    end else if (tick_q == TICK_LAST) begin
      tick_d = 16'h0000;
      ms_d = (ms_q == 8'hFF) ? ms_q : ms_q + 8'h01;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      tick_q <= 16'h0000;
      ms_q <= 8'h00;
    end else begin
      tick_q <= tick_d;
      ms_q <= ms_d;
    end
  end

  assign idle_hit = pack_en & hold_valid_q & ~hold_close_q &
                    (ms_q >= idle_q);

  // ****************************************************
  // Packing
  // ****************************************************
  assign byte_in = rx_valid & ~port_dis;
  assign match_en = (match_q[`MATCH_B1] != `MATCH_OFF) &&
                    (match_q[`MATCH_B2] != `MATCH_OFF);
  assign hit = pack_en & match_en & prev_valid_q &
               (prev_q == match_q[`MATCH_B1]) &&
               (rx_data == match_q[`MATCH_B2]);
  assign len_full = len_q >= (ctrl_q[`CTRL_ALT] ? ALT_LAST : STD_LAST);
  assign end_now = ~pack_en | len_full |
                   (ctrl_q[`CTRL_FRAME] &
                    ((hit & (trail_cfg_q == 8'h00)) |
                     (trail_act_q & (trail_cnt_q == 8'h01))));
  assign f_in_valid = hold_valid_q & (hold_close_q | byte_in);

  always_comb begin
    hold_valid_d = hold_valid_q;
    hold_close_d = hold_close_q;
    hold_data_d = hold_data_q;
    prev_valid_d = prev_valid_q;
    prev_d = prev_q;
    trail_act_d = trail_act_q;
    trail_cnt_d = trail_cnt_q;
    len_d = len_q;
    ovr_set = 1'b0;
    if (byte_in) begin
      if (hold_valid_q && !f_in_ready) begin
        ovr_set = 1'b1;
      end else begin
        hold_valid_d = 1'b1;
        hold_data_d = rx_data;
        hold_close_d = end_now;
        prev_d = rx_data;
        prev_valid_d = ~end_now;
        len_d = end_now ? 11'h000 : len_q + 11'h001;
        if (end_now) begin
          trail_act_d = 1'b0;
        end else if (hit && trail_cfg_q != 8'h00) begin
          trail_act_d = 1'b1;
          trail_cnt_d = trail_cfg_q;
        end else if (trail_act_q) begin
          trail_cnt_d = trail_cnt_q - 8'h01;
          trail_act_d = (trail_cnt_q != 8'h01);
        end
      end
    end else begin
      if (f_in_valid && f_in_ready) begin
        hold_valid_d = 1'b0;
        hold_close_d = 1'b0;
      end
      if (idle_hit) begin
        hold_close_d = 1'b1;
        len_d = 11'h000;
        prev_valid_d = 1'b0;
        trail_act_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      hold_valid_q <= 1'b0;
      hold_close_q <= 1'b0;
      hold_data_q <= 8'h00;
      prev_valid_q <= 1'b0;
      prev_q <= 8'h00;
      trail_act_q <= 1'b0;
      trail_cnt_q <= 8'h00;
      len_q <= 11'h000;
    end else begin
      hold_valid_q <= hold_valid_d;
      hold_close_q <= hold_close_d;
      hold_data_q <= hold_data_d;
      prev_valid_q <= prev_valid_d;
      prev_q <= prev_d;
      trail_act_q <= trail_act_d;
      trail_cnt_q <= trail_cnt_d;
      len_q <= len_d;
    end
  end

  serial_rx_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_in_valid(f_in_valid),
    .o_in_ready(f_in_ready),
    .i_in_data({hold_close_q, hold_data_q}),
    .o_out_valid(f_out_valid),
    .i_out_ready(f_out_ready),
    .o_out_data(f_out_data),
    .o_count(f_count)
  );

  // ****************************************************
  // Output stage
  // ****************************************************
  assign load = f_out_valid & (~o_pkt_valid | i_pkt_ready) & ~port_dis;
  assign f_out_ready = load;

  always_comb begin
    ov_d = load | (o_pkt_valid & ~i_pkt_ready);
    od_d = load ? f_out_data[7:0] : o_pkt_data;
    olast_d = load ? f_out_data[8] : o_pkt_last;
    txd_d = 1'b1;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_pkt_valid <= 1'b0;
      o_pkt_data <= 8'h00;
      o_pkt_last <= 1'b0;
      o_serial_txd <= 1'b1;
    end else begin
      o_pkt_valid <= ov_d;
      o_pkt_data <= od_d;
      o_pkt_last <= olast_d;
      o_serial_txd <= txd_d;
    end
  end
endmodule : serial_rx_packing_unit

// File: bench/serial_rx_packing_unit_checker.sv
`timescale 1ns/1ps
`include "serial_rx_defs.svh"
module serial_rx_packing_unit_checker (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Register bus
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // Serial and stream
  input wire logic i_serial_rxd,
  input wire logic o_serial_txd,
  input wire logic o_pkt_valid,
  input wire logic [7:0] o_pkt_data,
  input wire logic o_pkt_last,
  input wire logic i_pkt_ready
);
  // ********
  // Checks
  // ********
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  property p_answer;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer late");
  property p_one;
    !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_one: assert property (p_one)
    else $error("answer longer than one cycle");
  property p_cause;
    !o_avs_waitrequest |-> $past(i_avs_read || i_avs_write);
  endproperty
  a_cause: assert property (p_cause)
    else $error("answer without request");
  property p_txd;
    o_serial_txd;
  endproperty
  a_txd: assert property (p_txd)
    else $error("transmit line left idle level");
  property p_hold;
    o_pkt_valid && !i_pkt_ready |=>
      o_pkt_valid && $stable(o_pkt_data) && $stable(o_pkt_last);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stalled packet byte changed");
  property p_rd_hold;
    !(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without read");
  property p_unmapped;
    i_avs_read && o_avs_waitrequest && i_avs_address > `REG_STATUS
      |=> o_avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_idle_fld;
    i_avs_read && o_avs_waitrequest && i_avs_address == `REG_IDLE
      |=> o_avs_readdata[31:8] == 24'h0;
  endproperty
  a_idle_fld: assert property (p_idle_fld)
    else $error("gap register upper bits set");
endmodule : serial_rx_packing_unit_checker

bind serial_rx_packing_unit serial_rx_packing_unit_checker chk (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_serial_rxd(i_serial_rxd),
  .o_serial_txd(o_serial_txd), .o_pkt_valid(o_pkt_valid),
  .o_pkt_data(o_pkt_data), .o_pkt_last(o_pkt_last),
  .i_pkt_ready(i_pkt_ready));

// File: bench/serial_device_model.sv
`timescale 1ns/1ps
module serial_device_model (
  // Clock
  input wire logic i_core_clk,
  // Serial line
  output logic o_rxd
);
  // ********
  // Sender
  // ********
  initial o_rxd = 1'b1;
  task automatic put(input logic v, input int div);
    o_rxd <= v;
    repeat (div) @(posedge i_core_clk);
  endtask : put
  task automatic send(input logic [7:0] d, input int n, input int div);
    put(1'b0, div);
    for (int i = 0; i < n; i++) begin
      put(d[i], div);
    end
    put(1'b1, div);
  endtask : send
  task automatic send_p(input logic [7:0] d, input logic p, input int div);
    put(1'b0, div);
    for (int i = 0; i < 8; i++) begin
      put(d[i], div);
    end
    put(p, div);
    put(1'b1, div);
    put(1'b1, div);
  endtask : send_p
endmodule : serial_device_model

// File: bench/serial_rx_packing_unit_test.sv
`timescale 1ns/1ps
`include "serial_rx_defs.svh"
module serial_rx_packing_unit_test;
  // ********
  // Signals
  // ********
  localparam int DIV = `CORE_CLK_HZ / `BAUD_921600;
  localparam int NR = 8;
  logic i_core_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [4:0] i_avs_address = 5'h00;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [3:0] i_avs_byteenable = 4'hF;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic i_serial_rxd;
  logic o_serial_txd;
  logic o_pkt_valid;
  logic o_pkt_last;
  logic [7:0] o_pkt_data;
  logic i_pkt_ready = 1'b0;
  int n_fail = 0;
  int n_compared = 0;
  logic [8:0] got_q[$];
  logic [31:0] q;
  logic [NR-1:0] rw = 8'hE0;
  logic [4:0] ra [NR] = '{`REG_CTRL, `REG_SERIAL, `REG_IDLE, `REG_MATCH,
    `REG_TRAIL, 5'h18, `REG_SERIAL, `REG_TRAIL};
  logic [31:0] rd [NR] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hFFFF,
    32'h3C, 32'hFF};
  logic [31:0] re [NR] = '{32'h0, 32'h35, 32'hC, 32'h0, 32'h0, 32'h0,
    32'h3C, 32'hFF};
  logic [7:0] mb [8] = '{8'h0D, 8'h44, 8'h0A, 8'h11, 8'h0D, 8'h0A, 8'h22,
    8'h33};

  always #12.5 i_core_clk = ~i_core_clk;

  serial_rx_packing_unit #(.IDLE_TICK_CYCLES(100)) dut (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_serial_rxd(i_serial_rxd),
    .o_serial_txd(o_serial_txd), .o_pkt_valid(o_pkt_valid),
    .o_pkt_data(o_pkt_data), .o_pkt_last(o_pkt_last),
    .i_pkt_ready(i_pkt_ready));
  serial_device_model dev (.i_core_clk(i_core_clk), .o_rxd(i_serial_rxd));

  // Sink stalls every other cycle
  always @(posedge i_core_clk) begin
    i_pkt_ready <= ~i_pkt_ready;
    if (o_pkt_valid === 1'b1 && i_pkt_ready === 1'b1) begin
      got_q.push_back({o_pkt_last, o_pkt_data});
    end
  end

  // ********
  // Tasks
  // ********
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      n_fail++;
    end
  endtask : chk
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_core_clk);
    i_avs_address <= a;
    i_avs_write <= w;
    i_avs_read <= ~w;
    i_avs_writedata <= d;
    do begin
      @(posedge i_core_clk);
      k++;
    end while (o_avs_waitrequest !== 1'b0 && k < 100);
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    if (k >= 100) chk("bus_answer", 32'h0, 32'h1);
  endtask : bus
  task automatic pkt(input logic [8:0] e);
    int k;
    k = 0;
    while (got_q.size() == 0 && k < 5000) begin
      @(posedge i_core_clk);
      k++;
    end
    if (got_q.size() == 0) chk("pkt_seen", 32'h1, 32'h0);
    else chk("pkt", {23'h0, e}, {23'h0, got_q.pop_front()});
  endtask : pkt
  task automatic results();
    if (n_fail == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  initial begin
    repeat (60000) @(posedge i_core_clk);
    chk("timeout", 32'h0, 32'h1);
    results();
  end

  // ********
  // Sequence
  // ********
  initial begin
    repeat (5) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    for (int i = 0; i < NR; i++) begin
      if (rw[i]) bus(1'b1, ra[i], rd[i]);
      bus(1'b0, ra[i], 32'h0);
      chk("reg", re[i], q);
    end
    dev.send(8'hA5, 8, DIV);
    pkt(9'h1A5);
    bus(1'b1, `REG_SERIAL, 32'h2C);
    dev.send(8'hDA, 7, DIV);
    pkt(9'h15A);
    bus(1'b1, `REG_SERIAL, 32'h3C);
    bus(1'b1, `REG_CTRL, 32'h2);
    for (int i = 0; i < 3; i++) dev.send(8'h30 + 8'(i), 8, DIV);
    for (int i = 0; i < 3; i++) pkt({i == 2, 8'h30 + 8'(i)});
    bus(1'b1, `REG_MATCH, 32'h0A0D);
    bus(1'b1, `REG_TRAIL, 32'h1);
    bus(1'b1, `REG_CTRL, 32'hA);
    for (int i = 0; i < 8; i++) dev.send(mb[i], 8, DIV);
    for (int i = 0; i < 8; i++) pkt({i >= 6, mb[i]});
    bus(1'b1, `REG_CTRL, 32'h2);
    for (int i = 4; i < 8; i++) dev.send(mb[i], 8, DIV);
    for (int i = 4; i < 8; i++) pkt({i == 7, mb[i]});
    bus(1'b1, `REG_CTRL, 32'h1);
    dev.send(8'h55, 8, DIV);
    repeat (1500) @(posedge i_core_clk);
    chk("quiet", 32'h0, got_q.size());
    chk("txd", 32'h1, {31'h0, o_serial_txd});
    bus(1'b1, `REG_CTRL, 32'h0);
    dev.send(8'h66, 8, DIV);
    pkt(9'h166);
    bus(1'b1, `REG_SERIAL, 32'h1BC);
    dev.send_p(8'hA5, 1'b1, DIV);
    pkt(9'h1A5);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk("perr", 32'h1, q);
    bus(1'b1, `REG_STATUS, 32'h1);
    dev.send_p(8'hA5, 1'b0, DIV);
    pkt(9'h1A5);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk("status", 32'h0, q);
    @(posedge i_core_clk);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    bus(1'b0, `REG_SERIAL, 32'h0);
    chk("rst_serial", 32'h35, q);
    results();
  end
endmodule : serial_rx_packing_unit_test
